/* File: src/mcl_pkg.sv */
// modem-control lines package: register offsets, field positions, reset values, receive timing
// assumes a byte-wide register port with a 3-bit address and one 250 MHz clock
//
// What this block does
// - each user output pin goes active (low) while its modem-control bit is set.
// - each user output pin goes inactive high on master reset, in loop mode, or when its own bit (2 or 3) is clear.
// - the request-to-send pin goes active (low) while the request-to-send modem-control bit is set.
// - request-to-send goes inactive high on master reset, in loop mode, or when modem-control bit 1 is clear.
// - modem status bit 6 shows the present state of the ring-indicator input.
// - modem status bit 2 is set when the ring-indicator pin goes from low to high after the last status read.
// - that low-to-high ring transition raises the interrupt while the modem status interrupt is enabled.
// - the receiver timing is taken from the receive clock input, which runs at sixteen times the bit rate.
// - the serial output pin sits at marking (one) while master reset is applied.
// - data-terminal-ready goes active when modem-control bit 0 is set, inactive on master reset, loop or clear.
// - the interrupt output stays high while an enabled condition is pending and drops when serviced or reset.
package mcl_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;

  // register offsets on the 3-bit port
  localparam logic [2:0] ADDR_INT_ENABLE = 3'h1;
  localparam logic [2:0] ADDR_LINE_CTRL = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
  localparam logic [2:0] ADDR_RX_STATUS = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;

  // modem control fields
  localparam int MC_DTR_BIT = 0;
  localparam int MC_RTS_BIT = 1;
  localparam int MC_USER_FIRST_BIT = 2;
  localparam int MC_USER_SECOND_BIT = 3;
  localparam int MC_LOOP_BIT = 4;
  localparam logic [4:0] MODEM_CTRL_RESET = 5'h00;

  // modem status fields
  localparam int MS_RING_EDGE_BIT = 2;
  localparam int MS_RING_STATE_BIT = 6;

  // interrupt enable fields
  localparam int IE_MODEM_STATUS_BIT = 3;
  localparam logic [3:0] INT_ENABLE_RESET = 4'h0;

  // line control: only the break bit steers this block
  localparam int LC_BREAK_BIT = 6;
  localparam logic [7:0] LINE_CTRL_RESET = 8'h00;

  // receive timing status fields
  localparam int RS_SAMPLED_BIT = 0;
  localparam int RS_ACTIVE_BIT = 1;
  localparam int RS_FALSE_START_BIT = 2;

  // receive clock oversampling and frame length (start + 8 data + stop)
  localparam int unsigned RX_OVERSAMPLE = 16;
  localparam int unsigned RX_FRAME_BITS = 10;

  typedef enum logic [2:0] {
    MCL_RX_IDLE = 3'b001,
    MCL_RX_START = 3'b010,
    MCL_RX_BITS = 3'b100
  } mcl_rx_state_t;

endpackage : mcl_pkg

/* File: src/mcl_rx_if.sv */
// carrier between the line core and the receive timing module
// assumes both ends share clk
`timescale 1ns/1ns
`default_nettype none
interface mcl_rx_if;
  logic rclk_level;
  logic line_in;
  logic sample_tick;
  logic sampled_bit;
  logic active;
  logic false_start;

  modport core (
    output rclk_level,
    output line_in,
    input sample_tick,
    input sampled_bit,
    input active,
    input false_start
  );

  modport timer (
    input rclk_level,
    input line_in,
    output sample_tick,
    output sampled_bit,
    output active,
    output false_start
  );
endinterface : mcl_rx_if
`default_nettype wire

/* File: src/mcl_rx_timer.sv */
// receive bit timing derived from the 16x receive clock level
// assumes rclk_level is synchronous to clk and at most half the clk rate
`timescale 1ns/1ns
`default_nettype none
module mcl_rx_timer #(
  parameter int unsigned OVERSAMPLE = mcl_pkg::RX_OVERSAMPLE,
  parameter int unsigned FRAME_BITS = mcl_pkg::RX_FRAME_BITS
) (
  input wire logic clk,
  input wire logic rst_n,
  mcl_rx_if.timer rx
);
  localparam int CW = $clog2(OVERSAMPLE);
  localparam int BW = $clog2(FRAME_BITS + 1);

  mcl_pkg::mcl_rx_state_t state;
  logic rclk_prev;
  logic [CW-1:0] phase;
  logic [BW-1:0] bit_count;
  logic rclk_rise;

  assign rclk_rise = rx.rclk_level & ~rclk_prev;
  assign rx.active = (state != mcl_pkg::MCL_RX_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rclk_prev <= 1'b0;
    end else begin
      rclk_prev <= rx.rclk_level;
    end
  end

  // every step is paced by a receive clock edge, never by clk alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= mcl_pkg::MCL_RX_IDLE;
      phase <= '0;
      bit_count <= '0;
      rx.sample_tick <= 1'b0;
      rx.sampled_bit <= 1'b1;
      rx.false_start <= 1'b0;
    end else begin
      rx.sample_tick <= 1'b0;
      rx.false_start <= 1'b0;
      if (rclk_rise) begin
        unique case (state)
          mcl_pkg::MCL_RX_IDLE: begin
            phase <= '0;
            bit_count <= '0;
            if (!rx.line_in) begin
              state <= mcl_pkg::MCL_RX_START;
            end
          end
          mcl_pkg::MCL_RX_START: begin
            // recheck at mid start bit so a glitch is not taken as a frame
            if (phase == CW'(OVERSAMPLE / 2 - 1)) begin
              phase <= '0;
              if (rx.line_in) begin
                state <= mcl_pkg::MCL_RX_IDLE;
                rx.false_start <= 1'b1;
              end else begin
                state <= mcl_pkg::MCL_RX_BITS;
                bit_count <= BW'(1);
                rx.sample_tick <= 1'b1;
                rx.sampled_bit <= rx.line_in;
              end
            end else begin
              phase <= phase + CW'(1);
            end
          end
          mcl_pkg::MCL_RX_BITS: begin
            if (phase == CW'(OVERSAMPLE - 1)) begin
              phase <= '0;
              rx.sample_tick <= 1'b1;
              rx.sampled_bit <= rx.line_in;
              bit_count <= bit_count + BW'(1);
              if (bit_count == BW'(FRAME_BITS - 1)) begin
                state <= mcl_pkg::MCL_RX_IDLE;
              end
            end else begin
              phase <= phase + CW'(1);
            end
          end
          default: begin
            state <= mcl_pkg::MCL_RX_IDLE;
          end
        endcase
      end
    end
  end
endmodule : mcl_rx_timer
`default_nettype wire

/* File: src/mcl_top.sv */
// modem-control and line pins of a serial element, with a small register port
// assumes all inputs synchronous to clk; master_reset_in is a level, high active
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module mcl_top #(
  parameter int unsigned RX_OVERSAMPLE = mcl_pkg::RX_OVERSAMPLE,
  parameter int unsigned RX_FRAME_BITS = mcl_pkg::RX_FRAME_BITS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_reset_in,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ring_ind_n,
  input wire logic rx_clk_in,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic dtr_n,
  output logic rts_n,
  output logic user_output_first_n,
  output logic user_output_second_n,
  output logic interrupt_out
);
  logic [4:0] modem_ctrl_reg;
  logic [3:0] int_enable_reg;
  logic [7:0] line_ctrl_reg;
  logic ring_prev;
  logic ring_trailing_edge_flag;
  logic false_start_seen;
  logic ring_rise;
  logic status_read;
  logic loop_mode;
  logic internal_line;
  logic [7:0] modem_status_val;
  logic [7:0] rx_status_val;
  logic [7:0] next_rdata;

  mcl_rx_if rx_link ();

  mcl_rx_timer #(
    .OVERSAMPLE(RX_OVERSAMPLE),
    .FRAME_BITS(RX_FRAME_BITS)
  ) u_rx_timer (
    .clk(clk),
    .rst_n(rst_n),
    .rx(rx_link.timer)
  );

  assign loop_mode = modem_ctrl_reg[mcl_pkg::MC_LOOP_BIT];
  // the line the transmitter would drive; loop mode feeds it back to the receiver
  assign internal_line = ~line_ctrl_reg[mcl_pkg::LC_BREAK_BIT];
  assign rx_link.rclk_level = rx_clk_in;
  assign rx_link.line_in = loop_mode ? internal_line : serial_in_pin;

  assign ring_rise = ring_ind_n & ~ring_prev;
  assign status_read = reg_rd && (reg_addr == mcl_pkg::ADDR_MODEM_STATUS);

  always_comb begin
    modem_status_val = 8'h00;
    modem_status_val[mcl_pkg::MS_RING_STATE_BIT] = ~ring_ind_n;
    modem_status_val[mcl_pkg::MS_RING_EDGE_BIT] = ring_trailing_edge_flag;
  end

  always_comb begin
    rx_status_val = 8'h00;
    rx_status_val[mcl_pkg::RS_SAMPLED_BIT] = rx_link.sampled_bit;
    rx_status_val[mcl_pkg::RS_ACTIVE_BIT] = rx_link.active;
    rx_status_val[mcl_pkg::RS_FALSE_START_BIT] = false_start_seen;
  end

  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      mcl_pkg::ADDR_INT_ENABLE: next_rdata = {4'h0, int_enable_reg};
      mcl_pkg::ADDR_LINE_CTRL: next_rdata = line_ctrl_reg;
      mcl_pkg::ADDR_MODEM_CTRL: next_rdata = {3'h0, modem_ctrl_reg};
      mcl_pkg::ADDR_RX_STATUS: next_rdata = rx_status_val;
      mcl_pkg::ADDR_MODEM_STATUS: next_rdata = modem_status_val;
      default: next_rdata = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // control registers; master reset clears them like the pin reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modem_ctrl_reg <= mcl_pkg::MODEM_CTRL_RESET;
      int_enable_reg <= mcl_pkg::INT_ENABLE_RESET;
      line_ctrl_reg <= mcl_pkg::LINE_CTRL_RESET;
    end else if (master_reset_in) begin
      modem_ctrl_reg <= mcl_pkg::MODEM_CTRL_RESET;
      int_enable_reg <= mcl_pkg::INT_ENABLE_RESET;
      line_ctrl_reg <= mcl_pkg::LINE_CTRL_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        mcl_pkg::ADDR_INT_ENABLE: int_enable_reg <= reg_wdata[3:0];
        mcl_pkg::ADDR_LINE_CTRL: line_ctrl_reg <= reg_wdata;
        mcl_pkg::ADDR_MODEM_CTRL: modem_ctrl_reg <= reg_wdata[4:0];
        default: begin
        end
      endcase
    end
  end

  // pin history starts inactive high so a pin held high at reset makes no edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ring_prev <= 1'b1;
    end else begin
      ring_prev <= ring_ind_n;
    end
  end

  // an edge in the same cycle as the status read survives the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ring_trailing_edge_flag <= 1'b0;
    end else if (master_reset_in) begin
      ring_trailing_edge_flag <= 1'b0;
    end else if (ring_rise) begin
      ring_trailing_edge_flag <= 1'b1;
    end else if (status_read) begin
      ring_trailing_edge_flag <= 1'b0;
    end
  end

  // sticky false-start note, cleared by reading the receive status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      false_start_seen <= 1'b0;
    end else if (master_reset_in) begin
      false_start_seen <= 1'b0;
    end else if (rx_link.false_start) begin
      false_start_seen <= 1'b1;
    end else if (reg_rd && (reg_addr == mcl_pkg::ADDR_RX_STATUS)) begin
      false_start_seen <= 1'b0;
    end
  end

  // interrupt follows the pending flag one cycle later; the status read services it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_out <= 1'b0;
    end else if (master_reset_in) begin
      interrupt_out <= 1'b0;
    end else begin
      interrupt_out <= ring_trailing_edge_flag & int_enable_reg[mcl_pkg::IE_MODEM_STATUS_BIT];
    end
  end

  // modem pins are active low; loop mode holds them all inactive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      user_output_first_n <= 1'b1;
      user_output_second_n <= 1'b1;
    end else if (master_reset_in || loop_mode) begin
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      user_output_first_n <= 1'b1;
      user_output_second_n <= 1'b1;
    end else begin
      dtr_n <= ~modem_ctrl_reg[mcl_pkg::MC_DTR_BIT];
      rts_n <= ~modem_ctrl_reg[mcl_pkg::MC_RTS_BIT];
      user_output_first_n <= ~modem_ctrl_reg[mcl_pkg::MC_USER_FIRST_BIT];
      user_output_second_n <= ~modem_ctrl_reg[mcl_pkg::MC_USER_SECOND_BIT];
    end
  end

  // no transmitter here: the pin idles at marking unless break is set outside loop mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_pin <= 1'b1;
    end else if (master_reset_in || loop_mode) begin
      serial_out_pin <= 1'b1;
    end else begin
      serial_out_pin <= internal_line;
    end
  end
endmodule : mcl_top
`default_nettype wire

/* File: tb/mcl_modem.sv */
// modem model: ring indicator, receive clock and serial data toward mcl_top
// assumes the bench calls its tasks right after a clk edge
`timescale 1ns/1ns
`default_nettype none
module mcl_modem (
  input wire logic clk,
  output logic ring_ind_n,
  output logic rx_clk_in,
  output logic serial_in_pin
);
  logic run;
  logic [1:0] div;
  initial begin
    ring_ind_n = 1'b1;
    rx_clk_in = 1'b0;
    serial_in_pin = 1'b1;
    run = 1'b0;
    div = 2'h0;
  end
  // quarter rate, held still while the clock task leaves run clear
  always @(posedge clk) begin
    if (run) begin
      div <= div + 2'h1;
      rx_clk_in <= div[1];
    end
  end
  task automatic ring(input logic lvl);
    @(posedge clk);
    ring_ind_n <= lvl;
  endtask : ring
  task automatic line(input logic lvl);
    @(posedge clk);
    serial_in_pin <= lvl;
  endtask : line
  task automatic clock(input logic on);
    @(posedge clk);
    run <= on;
  endtask : clock
endmodule : mcl_modem
`default_nettype wire

/* File: tb/mcl_top_assertions.sv */
// timing checks on the modem pins, read port and ring flag of mcl_top
// bound to mcl_top from the bench top; sees only its ports
`timescale 1ns/1ns
`default_nettype none
module mcl_top_assertions #(
  parameter int unsigned RX_OVERSAMPLE = 16,
  parameter int unsigned RX_FRAME_BITS = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_reset_in,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ring_ind_n,
  input wire logic serial_out_pin,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic user_output_first_n,
  input wire logic user_output_second_n,
  input wire logic interrupt_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic mres = master_reset_in;
  wire logic mc_wr = reg_wr && reg_addr == 3'h4 && !mres;
  wire logic ms_rd = reg_rd && reg_addr == 3'h6;
  chk_marking_reset: assert property (mres |=> serial_out_pin)
    else $error("serial out not marking after master reset");
  chk_pins_reset: assert property (mres |=> dtr_n && rts_n && user_output_first_n && user_output_second_n)
    else $error("modem pins active after master reset");
  chk_int_reset: assert property (mres |=> !interrupt_out)
    else $error("interrupt active after master reset");
  chk_dtr_follow: assert property (mc_wr ##1 !mres |=> dtr_n == !($past(reg_wdata[0], 2) && !$past(reg_wdata[4], 2)))
    else $error("dtr pin does not follow its bit");
  chk_rts_follow: assert property (mc_wr ##1 !mres |=> rts_n == !($past(reg_wdata[1], 2) && !$past(reg_wdata[4], 2)))
    else $error("rts pin does not follow its bit");
  chk_user1_follow: assert property (mc_wr ##1 !mres |=>
    user_output_first_n == !($past(reg_wdata[2], 2) && !$past(reg_wdata[4], 2)))
    else $error("first user pin does not follow its bit");
  chk_user2_follow: assert property (mc_wr ##1 !mres |=>
    user_output_second_n == !($past(reg_wdata[3], 2) && !$past(reg_wdata[4], 2)))
    else $error("second user pin does not follow its bit");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_ring_state: assert property (ms_rd && $stable(ring_ind_n) |=> reg_rdata[6] == !$past(ring_ind_n))
    else $error("ring state bit wrong");
  chk_ring_flag: assert property (($rose(ring_ind_n) && !mres) ##1 (!reg_rd && !mres) [*4] ##1 (ms_rd && !mres) |=> reg_rdata[2])
    else $error("ring edge flag not set");
  chk_int_clear: assert property ((ms_rd && ring_ind_n && $past(ring_ind_n)) ##1 ring_ind_n |=> !interrupt_out)
    else $error("interrupt stays after status read");
endmodule : mcl_top_assertions
`default_nettype wire

/* File: tb/modem_control_lines_test.sv */
// self-checking bench for mcl_top with a modem model on the line side
// assumes mcl_modem drives ring, receive clock and serial input
`timescale 1ns/1ns
`default_nettype none
module modem_control_lines_test;
  logic clk, rst_n, master_reset_in, reg_wr, reg_rd;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  wire logic [7:0] reg_rdata;
  wire logic ring_ind_n, rx_clk_in, serial_in_pin, serial_out_pin, dtr_n, rts_n;
  wire logic user_output_first_n, user_output_second_n, interrupt_out;
  int mismatches = 0;
  int n_tests = 0;
  wire logic [4:0] pins = {serial_out_pin, user_output_second_n, user_output_first_n, rts_n, dtr_n};
  mcl_top dut_u (.clk, .rst_n, .master_reset_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ring_ind_n, .rx_clk_in, .serial_in_pin, .serial_out_pin, .dtr_n, .rts_n, .user_output_first_n,
    .user_output_second_n, .interrupt_out);
  mcl_modem modem_u (.clk, .ring_ind_n, .rx_clk_in, .serial_in_pin);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one strobe cycle; w picks write or read so both strobes follow the caller
  task automatic strobe(input logic w, input logic [2:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    strobe(1'b1, a, d);
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] mask, input logic [7:0] exp, input string what);
    strobe(1'b0, a, reg_wdata);
    #1 check(what, exp, reg_rdata & mask);
    @(posedge clk);
  endtask : rd
  task automatic pin(input logic [4:0] exp, input logic irq);
    #1 check("pins", {3'h0, exp}, {3'h0, pins});
    check("interrupt", {7'h0, irq}, {7'h0, interrupt_out});
    @(posedge clk);
  endtask : pin
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    rst_n = 1'b0;
    master_reset_in = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    pin(5'h1f, 1'b0);
    $display("test reset done");
    for (int b = 0; b < 4; b++) begin
      wr(3'h4, 8'h01 << b);
      pin(5'h1f ^ (5'h01 << b), 1'b0);
    end
    wr(3'h4, 8'h00);
    pin(5'h1f, 1'b0);
    wr(3'h4, 8'h0f);
    pin(5'h10, 1'b0);
    wr(3'h4, 8'h1f);
    pin(5'h1f, 1'b0);
    wr(3'h4, 8'h0f);
    wr(3'h3, 8'h40);
    pin(5'h00, 1'b0);
    master_reset_in <= 1'b1;
    repeat (3) @(posedge clk);
    pin(5'h1f, 1'b0);
    master_reset_in <= 1'b0;
    @(posedge clk);
    pin(5'h1f, 1'b0);
    $display("test pins done");
    modem_u.ring(1'b0);
    repeat (2) @(posedge clk);
    rd(3'h6, 8'h44, 8'h40, "ring state");
    wr(3'h1, 8'h08);
    modem_u.ring(1'b1);
    repeat (4) @(posedge clk);
    pin(5'h1f, 1'b1);
    rd(3'h6, 8'h44, 8'h04, "ring edge");
    pin(5'h1f, 1'b0);
    rd(3'h6, 8'h04, 8'h00, "flag after read");
    wr(3'h1, 8'h00);
    modem_u.ring(1'b0);
    modem_u.ring(1'b1);
    repeat (4) @(posedge clk);
    pin(5'h1f, 1'b0);
    rd(3'h6, 8'h04, 8'h04, "masked edge");
    $display("test ring done");
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h44, 8'h00, "status after write");
    rd(3'h7, 8'hff, 8'h00, "unmapped");
    // a low pulse shorter than half a bit must be dropped as a false start
    modem_u.clock(1'b1);
    repeat (8) @(posedge clk);
    modem_u.line(1'b0);
    repeat (5) @(posedge clk);
    modem_u.line(1'b1);
    repeat (48) @(posedge clk);
    rd(3'h5, 8'h06, 8'h04, "false start");
    rd(3'h5, 8'h04, 8'h00, "false start cleared");
    modem_u.clock(1'b0);
    modem_u.line(1'b0);
    repeat (20) @(posedge clk);
    rd(3'h5, 8'h02, 8'h00, "receiver without clock");
    modem_u.clock(1'b1);
    repeat (60) @(posedge clk);
    rd(3'h5, 8'h02, 8'h02, "receiver active");
    modem_u.line(1'b1);
    modem_u.clock(1'b0);
    $display("test receive done");
    summarize();
  end
  // whole sequence takes well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule : modem_control_lines_test
bind mcl_top mcl_top_assertions #(.RX_OVERSAMPLE(RX_OVERSAMPLE), .RX_FRAME_BITS(RX_FRAME_BITS)) chk_u (.clk,
  .rst_n, .master_reset_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ring_ind_n, .serial_out_pin,
  .dtr_n, .rts_n, .user_output_first_n, .user_output_second_n, .interrupt_out);
`default_nettype wire
